// >>> dual_port_pkg.sv
package dual_port_pkg;

  // Port count and function codes seen during information transfer
  localparam int          NPORTS        = 2;
  localparam logic [7:0]  FC_RESERVE    = 8'h14;
  localparam logic [7:0]  FC_RELEASE    = 8'h15;
  localparam logic [7:0]  FC_SEM_A      = 8'h2A;
  localparam logic [7:0]  FC_SEM_B      = 8'h2B;
  localparam logic [7:0]  FC_NOTIFY_FMT = 8'h0C;

  // Register byte offsets
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STAT0_OFS     = 8'h04;
  localparam logic [7:0]  STAT1_OFS     = 8'h08;
  localparam logic [7:0]  EXT_OFS       = 8'h0C;

  // Control register fields and reset value
  localparam int          CTRL_W        = 4;
  localparam logic [3:0]  CTRL_RESET    = 4'h3;
  localparam int          CTRL_EN0      = 0;
  localparam int          CTRL_EN1      = 1;
  localparam int          CTRL_NLB_ATTN = 2;
  localparam int          CTRL_NLB_INTR = 3;

  // Sticky flag positions per port
  localparam int          FLAG_W        = 5;
  localparam int          FLG_UNSOL     = 0;
  localparam int          FLG_ALT_PRIO  = 1;
  localparam int          FLG_ALT_FMT   = 2;
  localparam int          FLG_ALT_TM    = 3;
  localparam int          FLG_PEND      = 4;
  localparam int          W1C_W         = 4;

  // Status word positions above the sticky flags
  localparam int          ST_PHYS       = 4;
  localparam int          ST_LOG        = 5;
  localparam int          ST_SEL        = 6;
  localparam int          ST_BUSY       = 7;
  localparam int          ST_PEND       = 8;
  localparam int          ST_PTCTL      = 9;

  // Events from one port's sequence logic, one-cycle strobes
  typedef struct packed {
    logic       sel_req;    // Selection sequence strobe
    logic       hold_bit;   // hold_priority_bit of selection octet
    logic       ovr_bit;    // override_priority_bit of selection octet
    logic       desel;      // Deselection strobe
    logic       fc_valid;   // Function code transferred
    logic [7:0] fc_code;    // Function code value
    logic       xfer_start; // Media transfer started here
    logic       xfer_done;  // Media transfer ended
    logic       slave_reset;// Slave reset received
    logic       reset_done; // Reset completion
    logic       fmt_changed;// Format specification accepted
    logic       tm_changed; // Target modifier changed
    logic       intr_set;   // Interrupt condition raised
    logic       intr_taken; // Interrupt octet presented
    logic       ptctl_load; // Port control load accepted
    logic       ptctl_val;  // Disable allegiance effect on interrupts
  } port_event_type;

  // Answers to one port
  typedef struct packed {
    logic sel_ack;     // Bit-significant response at selection
    logic phys_busy;   // Selection refused
    logic log_busy;    // Logical busy for ending status
    logic intr_report; // Interrupt may be presented
    logic attention;   // No-longer-busy attention in
    logic unsol_exc;   // Unsolicited exception in status
  } port_resp_type;

endpackage

// >>> flag_bank.sv
`timescale 1ns/1ps
// Sticky flags: a set in the clear cycle wins
module flag_bank
  import dual_port_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic [FLAG_W-1:0] i_set,
  input  wire logic [FLAG_W-1:0] i_clr,
  output logic      [FLAG_W-1:0] o_flags
);

  logic [FLAG_W-1:0] flags_r;   // Held flags
  logic [FLAG_W-1:0] flags_nxt; // Next value

  assign flags_nxt = (flags_r & ~i_clr) | i_set;
  assign o_flags   = flags_r;

  // Flag storage
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

endmodule // flag_bank

// >>> dual_port_allegiance_control.sv
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Reserve code sets logical allegiance, survives deselect
// - Release code from same port clears it
// - Override depends on holder's hold/select bits
// - Refuse selection while other port holds allegiance
// - Withhold interrupts during other-port allegiance, report later
// - Port control setting lifts that suppression
// - Report interrupt only when neither busy nor selected
// - Alternate-port events except target modifier change raise unsolicited exception
// - Physical busy withholds bit-significant response
// - Logical busy goes in ending slave status
// - Other port's allegiance answers selection with busy
// - Logical busy only at initiating port
// - Other port's media transfer answers with busy
// - Optional no-longer-busy interrupt after refusal
// - Attention in when allegiance-caused busy ends
// - Format, buffer and assembly shared by ports
// - Status shows alternate flags, allegiance holders, enables
// - Hold bit at selection enables physical allegiance
// - Slave reset at either port clears allegiance
// - Port control load stops other allegiance withholding interrupts, not selections
module dual_port_allegiance_control
  import dual_port_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_hsel,
  input  wire logic [31:0]               i_haddr,
  input  wire logic [1:0]                i_htrans,
  input  wire logic                      i_hwrite,
  input  wire logic [2:0]                i_hsize,
  input  wire logic [31:0]               i_hwdata,
  input  wire logic                      i_hready,
  input  wire port_event_type [NPORTS-1:0] i_port_evt,
  output logic      [31:0]               o_hrdata,
  output logic                           o_hreadyout,
  output logic                           o_hresp,
  output port_resp_type [NPORTS-1:0]     o_port_resp
);

  // Per-port registered state
  logic [NPORTS-1:0] sel_r;      // Selected now
  logic [NPORTS-1:0] phys_r;     // Physical explicit allegiance
  logic [NPORTS-1:0] hold_r;     // Hold bit of last selection
  logic [NPORTS-1:0] ovr_r;      // Select bit of last selection
  logic [NPORTS-1:0] log_r;      // Logical explicit allegiance
  logic [NPORTS-1:0] xfer_r;     // Media transfer running
  logic [NPORTS-1:0] ptctl_r;    // Port control override
  logic [NPORTS-1:0] refused_r;  // Refused, waiting for free
  logic [NPORTS-1:0] by_alleg_r; // Refusal caused by allegiance
  logic [NPORTS-1:0] ack_r;      // Response pulse
  logic [NPORTS-1:0] pbusy_r;    // Refusal pulse
  logic [NPORTS-1:0] intr_r;     // Interrupt report level
  logic [NPORTS-1:0] attn_r;     // Attention pulse

  // Bus side state
  logic [CTRL_W-1:0] ctrl_r;     // Control register
  logic              wr_pend_r;  // Write data phase due
  logic [7:0]        wr_addr_r;  // Write address
  logic [31:0]       hrdata_r;   // Read data
  logic              hready_r;   // Ready out
  logic              hresp_r;    // Response, always OKAY

  // Combinational decisions
  wire  [NPORTS-1:0] alleg = sel_r | phys_r | log_r; // Allegiance held
  // Slave reset from either port
  wire               any_reset = i_port_evt[0].slave_reset | i_port_evt[1].slave_reset;
  // Ports that software has enabled
  wire  [NPORTS-1:0] port_en = {ctrl_r[CTRL_EN1], ctrl_r[CTRL_EN0]};
  wire  [NPORTS-1:0] can_ovr;    // Incoming selection overrides
  wire  [NPORTS-1:0] blocked;    // Other port busy or holding
  wire  [NPORTS-1:0] accept;     // Selection honoured
  wire  [NPORTS-1:0] refuse;     // Selection refused
  wire  [NPORTS-1:0] lost;       // Allegiance taken by other port
  wire  [NPORTS-1:0] free_now;   // Other port available now
  // Per-port sticky flag set, clear and state
  wire  [FLAG_W-1:0] fl_set [NPORTS];
  wire  [FLAG_W-1:0] fl_clr [NPORTS];
  wire  [FLAG_W-1:0] flags  [NPORTS];
  // Status words for the read mux
  wire  [31:0]       stat_word [NPORTS];

  // Bus decode
  // Address phase of a transfer to this slave
  wire               addr_ph  = i_hsel & i_htrans[1] & i_hready;
  // Register offset within the block
  wire  [7:0]        addr_lo  = i_haddr[7:0];
  // Control register written in this data phase
  wire               wr_ctrl  = wr_pend_r & (wr_addr_r == CTRL_OFS);
  // Status flags written in this data phase
  wire  [NPORTS-1:0] wr_stat  = {wr_pend_r & (wr_addr_r == STAT1_OFS),
                                 wr_pend_r & (wr_addr_r == STAT0_OFS)};
  // Extended status: allegiance holders and port enables
  wire  [31:0]       ext_word = {26'h0, alleg, 2'h0, port_en};
  // Read mux by offset; unmapped offsets read zero
  wire  [31:0]       rd_word  = (addr_lo == CTRL_OFS)  ? {28'h0, ctrl_r} :
                                (addr_lo == STAT0_OFS) ? stat_word[0] :
                                (addr_lo == STAT1_OFS) ? stat_word[1] :
                                (addr_lo == EXT_OFS)   ? ext_word : 32'h0;

  // One copy of the arbitration logic per port
  genvar p;
  generate
    for (p = 0; p < NPORTS; p++) begin : g_port
      // Index of the other port
      localparam int Q = NPORTS - 1 - p;
      // Function code seen while this port is selected
      wire ev_fc = i_port_evt[p].fc_valid & sel_r[p];
      wire reserve = ev_fc & (i_port_evt[p].fc_code == FC_RESERVE);
      wire release_c = ev_fc & (i_port_evt[p].fc_code == FC_RELEASE);

      // Function code seen at the other port
      wire q_fc = i_port_evt[Q].fc_valid & sel_r[Q];
      wire q_note = q_fc & ((i_port_evt[Q].fc_code == FC_NOTIFY_FMT) |
                            (i_port_evt[Q].fc_code == FC_SEM_A) |
                            (i_port_evt[Q].fc_code == FC_SEM_B));
      // Other port won a selection carrying its select bit
      wire q_prio = accept[Q] & i_port_evt[Q].ovr_bit;

      // Same-cycle requests: port 0 goes first
      wire tie = (p == 1) & i_port_evt[0].sel_req & port_en[0];

      // neither busy nor selected; other allegiance withholds
      wire report_ok = ~xfer_r[p] & ~sel_r[p] & (~alleg[Q] | ptctl_r[p]);
      wire nlb_intr = refused_r[p] & free_now[p] & ctrl_r[CTRL_NLB_INTR];

      // override needs select; held-with-select cannot be taken
      assign can_ovr[p]  = i_port_evt[p].ovr_bit &
                           (~hold_r[Q] | (~ovr_r[Q] & i_port_evt[p].hold_bit));
      assign blocked[p]  = alleg[Q] | xfer_r[Q];
      assign accept[p]   = i_port_evt[p].sel_req & port_en[p] & ~any_reset &
                           ((~blocked[p] & ~tie) | can_ovr[p]);
      // Any request not honoured is refused
      assign refuse[p]   = i_port_evt[p].sel_req & ~accept[p];
      // Other port overrode this port's hold
      assign lost[p]     = accept[Q] & blocked[Q];
      // Neither allegiance nor transfer at the other port
      assign free_now[p] = ~blocked[p];

      // one format spec, so a change flags the other port
      assign fl_set[p][FLG_UNSOL]    = q_prio | i_port_evt[Q].fmt_changed |
                                       i_port_evt[Q].reset_done | q_note;
      assign fl_set[p][FLG_ALT_PRIO] = q_prio;
      assign fl_set[p][FLG_ALT_FMT]  = i_port_evt[Q].fmt_changed;
      assign fl_set[p][FLG_ALT_TM]   = i_port_evt[Q].tm_changed;
      // Raised interrupt or no-longer-busy interrupt
      assign fl_set[p][FLG_PEND]     = i_port_evt[p].intr_set | nlb_intr;
      // Software clears the alternate flags by writing ones
      assign fl_clr[p][W1C_W-1:0]    = wr_stat[p] ? i_hwdata[W1C_W-1:0] : 4'h0;
      assign fl_clr[p][FLG_PEND]     = i_port_evt[p].intr_taken & intr_r[p];

      // Read status word of this port
      assign stat_word[p] = {22'h0, ptctl_r[p], flags[p][FLG_PEND], xfer_r[p],
                             sel_r[p], log_r[p], phys_r[p], flags[p][W1C_W-1:0]};

      // Sticky flags of this port
      flag_bank u_flags (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_set     (fl_set[p]),
        .i_clr     (fl_clr[p]),
        .o_flags   (flags[p])
      );

      // Allegiance and selection state
      always_ff @(posedge i_clk) begin
        if (!i_reset_n || any_reset) begin
          sel_r[p]   <= 1'b0;
          phys_r[p]  <= 1'b0;
          hold_r[p]  <= 1'b0;
          ovr_r[p]   <= 1'b0;
          log_r[p]   <= 1'b0;
          xfer_r[p]  <= 1'b0;
          ptctl_r[p] <= 1'b0;
        end else if (lost[p]) begin
          // Overridden: operation may be abandoned
          sel_r[p]   <= 1'b0;
          phys_r[p]  <= 1'b0;
          hold_r[p]  <= 1'b0;
          ovr_r[p]   <= 1'b0;
          log_r[p]   <= 1'b0;
          xfer_r[p]  <= 1'b0;
        end else begin
          // Honoured selection records its octet bits
          if (accept[p]) begin
            sel_r[p]  <= 1'b1;
            hold_r[p] <= i_port_evt[p].hold_bit;
            ovr_r[p]  <= i_port_evt[p].ovr_bit;
            phys_r[p] <= i_port_evt[p].hold_bit;
          end else if (i_port_evt[p].desel) begin
            // Deselection ends implicit allegiance
            sel_r[p] <= 1'b0;
          end
          if (reserve) begin
            log_r[p] <= 1'b1;
          end else if (release_c) begin
            log_r[p] <= 1'b0;
          end
          // Media transfer tracking
          if (i_port_evt[p].xfer_start && sel_r[p]) begin
            xfer_r[p] <= 1'b1;
          end else if (i_port_evt[p].xfer_done) begin
            xfer_r[p] <= 1'b0;
          end
          if (i_port_evt[p].ptctl_load && sel_r[p]) begin
            ptctl_r[p] <= i_port_evt[p].ptctl_val;
          end
        end
      end

      // Answers and busy bookkeeping
      always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
          // No answers or refusals pending after reset
          ack_r[p]      <= 1'b0;
          pbusy_r[p]    <= 1'b0;
          intr_r[p]     <= 1'b0;
          attn_r[p]     <= 1'b0;
          refused_r[p]  <= 1'b0;
          by_alleg_r[p] <= 1'b0;
        end else begin
          ack_r[p]   <= accept[p];
          // Refusal pulse signals physical busy
          pbusy_r[p] <= refuse[p];
          // Interrupt level follows pending and permission
          intr_r[p]  <= flags[p][FLG_PEND] & report_ok;
          attn_r[p]  <= refused_r[p] & by_alleg_r[p] & free_now[p] &
                        ctrl_r[CTRL_NLB_ATTN];

          // Remember a refusal until the other port frees
          if (refuse[p]) begin
            refused_r[p]  <= 1'b1;
            by_alleg_r[p] <= alleg[Q];
          end else if (free_now[p]) begin
            refused_r[p]  <= 1'b0;
            by_alleg_r[p] <= 1'b0;
          end
        end
      end

      // logical busy only at initiating port
      assign o_port_resp[p] = '{sel_ack:     ack_r[p],
                                phys_busy:   pbusy_r[p],
                                log_busy:    xfer_r[p],
                                intr_report: intr_r[p],
                                attention:   attn_r[p],
                                unsol_exc:   flags[p][FLG_UNSOL]};
    end
  endgenerate

  // Bus slave: zero wait states, read data caught at address phase
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      // Both ports enabled after reset
      ctrl_r    <= CTRL_RESET;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0;
      hready_r  <= 1'b1;
      hresp_r   <= 1'b0;
    end else begin
      // Write data follows one cycle after its address
      wr_pend_r <= addr_ph & i_hwrite;
      // Keep the address for the data phase
      if (addr_ph) begin
        wr_addr_r <= addr_lo;
      end
      // Read word is caught at the address phase
      if (addr_ph && !i_hwrite) begin
        hrdata_r <= rd_word;
      end
      // Control register takes the written word
      if (wr_ctrl) begin
        ctrl_r <= i_hwdata[CTRL_W-1:0];
      end
      // No wait states and never an error
      hready_r <= 1'b1;
      hresp_r  <= 1'b0;
    end
  end

  // Bus outputs straight from their registers
  assign o_hrdata    = hrdata_r;
  assign o_hreadyout = hready_r;
  assign o_hresp     = hresp_r;

endmodule // dual_port_allegiance_control

// >>> dual_port_props.sv
`timescale 1ns/1ps
// Watches the port answers of the arbiter
module dual_port_props
  import dual_port_pkg::*;
(
  input  wire logic                        i_clk,
  input  wire logic                        i_reset_n,
  input  wire port_event_type [NPORTS-1:0] i_port_evt,
  input  wire logic                        o_hreadyout,
  input  wire logic                        o_hresp,
  input  wire port_resp_type  [NPORTS-1:0] o_port_resp
);
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Selection strobe at port 0
  sequence s_sel0;
    i_port_evt[0].sel_req;
  endsequence
  // Plain selection at port 1 while port 0 runs a transfer
  sequence s_sel1_xfer;
    o_port_resp[0].log_busy && i_port_evt[1].sel_req && !i_port_evt[1].ovr_bit;
  endsequence
  sel_answer_a:
    assert property (s_sel0 |=> o_port_resp[0].sel_ack != o_port_resp[0].phys_busy)
    else $error("port 0 selection answered wrongly");
  no_answer_a:
    assert property (!i_port_evt[1].sel_req |=>
      !(o_port_resp[1].sel_ack || o_port_resp[1].phys_busy))
    else $error("port 1 answered without a selection");
  xfer_refuse_a:
    assert property (s_sel1_xfer |=> o_port_resp[1].phys_busy)
    else $error("port 1 not busy during port 0 transfer");
  one_logbusy_a:
    assert property (!(o_port_resp[0].log_busy && o_port_resp[1].log_busy))
    else $error("logical busy at both ports");
  sel_quiet_a:
    assert property (o_port_resp[0].sel_ack |=> !o_port_resp[0].intr_report)
    else $error("interrupt reported while selected");
  busy_quiet_a:
    assert property (o_port_resp[0].log_busy |=> !o_port_resp[0].intr_report)
    else $error("interrupt reported while busy");
  attn_pulse_a:
    assert property ($rose(o_port_resp[1].attention) |=> !o_port_resp[1].attention)
    else $error("attention longer than one cycle");
  unsol_set_a:
    assert property ((i_port_evt[1].reset_done || i_port_evt[1].fmt_changed) |->
      ##[1:2] o_port_resp[0].unsol_exc)
    else $error("unsolicited exception missing at port 0");
  bus_okay_a:
    assert property (o_hreadyout && !o_hresp)
    else $error("bus slave not ready or not okay");
endmodule // dual_port_props

bind dual_port_allegiance_control dual_port_props u_props (
  .i_clk       (i_clk),
  .i_reset_n   (i_reset_n),
  .i_port_evt  (i_port_evt),
  .o_hreadyout (o_hreadyout),
  .o_hresp     (o_hresp),
  .o_port_resp (o_port_resp)
);

// >>> port_master_model.sv
`timescale 1ns/1ps
// One bus master controller facing one port of the drive
module port_master_model
  import dual_port_pkg::*;
(
  input  wire logic          i_clk,
  input  wire port_resp_type i_resp,
  output port_event_type     o_evt
);
  initial o_evt = '0;
  // One strobe cycle, then idle again
  task automatic send(input port_event_type e);
    @(posedge i_clk);
    o_evt <= e;
    @(posedge i_clk);
    o_evt <= '0;
  endtask
  task automatic select(input logic hold, input logic ovr, output logic ack);
    port_event_type e;
    e = '0;
    e.sel_req = 1'b1;
    e.hold_bit = hold;
    e.ovr_bit = ovr;
    send(e);
    @(posedge i_clk);
    ack = i_resp.sel_ack;
  endtask
  task automatic code(input logic [7:0] fc);
    port_event_type e;
    e = '0;
    e.fc_valid = 1'b1;
    e.fc_code = fc;
    send(e);
  endtask
  // Ends the selection at this port
  task automatic desel();
    port_event_type e;
    e = '0;
    e.desel = 1'b1;
    send(e);
  endtask
endmodule // port_master_model

// >>> tb_dual_port_allegiance_control.sv
`timescale 1ns/1ps
// Self-checking bench for the dual-port arbiter
module tb_dual_port_allegiance_control;
  import dual_port_pkg::*;
  localparam int INTR = 0, TAKEN = 1, XS = 2, XD = 3, SRST = 4, RDONE = 5, FMT = 6, TMC = 7;
  localparam int PCTL = 8;
  logic                        i_clk = 1'b0;
  logic                        i_reset_n = 1'b0;
  logic                        hsel = 1'b0;
  logic [31:0]                 haddr = '0;
  logic [1:0]                  htrans = '0;
  logic                        hwrite = 1'b0;
  logic [31:0]                 hwdata = '0;
  logic [31:0]                 hrdata;
  logic                        hready;
  logic                        hresp;
  port_event_type [NPORTS-1:0] evt;
  port_resp_type  [NPORTS-1:0] resp;
  int                          fail_count = 0;
  int                          total_checks = 0;
  int                          cycles = 0;
  integer                      seed = 32'h46B8;
  logic [31:0]                 rd;
  logic                        ack;
  logic                        seen;
  logic [3:0]                  cmb;
  logic                        exp_acc;

  always #25 i_clk = ~i_clk;

  dual_port_allegiance_control uut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .i_port_evt(evt), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .o_port_resp(resp));
  port_master_model m0 (.i_clk(i_clk), .i_resp(resp[0]), .o_evt(evt[0]));
  port_master_model m1 (.i_clk(i_clk), .i_resp(resp[1]), .o_evt(evt[1]));

  // Builds a one-strobe event of the given kind
  function automatic port_event_type ev(input int k);
    ev = '0;
    ev.intr_set = (k == INTR);
    ev.intr_taken = (k == TAKEN);
    ev.xfer_start = (k == XS);
    ev.xfer_done = (k == XD);
    ev.slave_reset = (k == SRST);
    ev.reset_done = (k == RDONE);
    ev.fmt_changed = (k == FMT);
    ev.tm_changed = (k == TMC);
    ev.ptctl_load = (k == PCTL);
    ev.ptctl_val = (k == PCTL);
  endfunction
  // Holder bits c[3:2], incoming bits c[1:0]: may the incoming port override
  function automatic logic may_override(input logic [3:0] c);
    return c[0] && (!c[3] || (!c[2] && c[1]));
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  // One single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge i_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge i_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    // Reset values, then an unmapped word
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, 32'(4 * k), '0);
      check(rd, (k == 0 || k == 3) ? 32'h3 : 32'h0);
    end
    // Interrupts withheld during other allegiance and while selected
    m0.select(1'b0, 1'b0, ack);
    m1.send(ev(INTR));
    m0.send(ev(INTR));
    repeat (3) @(posedge i_clk);
    check(32'(resp[1].intr_report), 32'h0);
    check(32'(resp[0].intr_report), 32'h0);
    m0.desel();
    repeat (3) @(posedge i_clk);
    check(32'(resp[1].intr_report), 32'h1);
    check(32'(resp[0].intr_report), 32'h1);
    bus(1'b0, 32'h8, '0);
    check(rd & 32'h100, 32'h100);
    m1.send(ev(TAKEN));
    m0.send(ev(TAKEN));
    repeat (3) @(posedge i_clk);
    check(32'(resp[1].intr_report), 32'h0);
    // Port control lifts the suppression
    m1.select(1'b0, 1'b0, ack);
    m1.send(ev(PCTL));
    m1.desel();
    m0.select(1'b0, 1'b0, ack);
    m1.send(ev(INTR));
    repeat (3) @(posedge i_clk);
    check(32'(resp[1].intr_report), 32'h1);
    m1.send(ev(TAKEN));
    m0.desel();
    // Reservation, refusal, release and the no-longer-busy signals
    bus(1'b1, 32'h0, 32'hF);
    m0.select(1'b0, 1'b0, ack);
    m0.code(FC_RESERVE);
    m0.desel();
    bus(1'b0, 32'h4, '0);
    check(rd & 32'h20, 32'h20);
    bus(1'b0, 32'hC, '0);
    check(rd & 32'h33, 32'h13);
    m1.select(1'b0, 1'b0, ack);
    check(32'(ack), 32'h0);
    m0.select(1'b0, 1'b0, ack);
    m0.code(FC_RELEASE);
    bus(1'b0, 32'h4, '0);
    check(rd & 32'h20, 32'h0);
    m0.desel();
    seen = 1'b0;
    repeat (6) begin
      @(posedge i_clk);
      seen = seen | resp[1].attention;
    end
    check(32'(seen), 32'h1);
    check(32'(resp[1].intr_report), 32'h1);
    m1.send(ev(TAKEN));
    // Media transfer at port 0
    m0.select(1'b0, 1'b0, ack);
    m0.send(ev(XS));
    @(posedge i_clk);
    check(32'({resp[1].log_busy, resp[0].log_busy}), 32'h1);
    m1.select(1'b0, 1'b0, ack);
    check(32'(ack), 32'h0);
    m0.send(ev(XD));
    m0.desel();
    // Every override combination, then random ones
    for (int i = 0; i < 24; i++) begin
      cmb = (i < 16) ? 4'(i) : 4'($random(seed));
      exp_acc = may_override(cmb);
      m0.select(cmb[3], cmb[2], ack);
      m0.code(FC_RESERVE);
      m0.desel();
      bus(1'b0, 32'h4, '0);
      check((rd >> 4) & 32'h1, 32'(cmb[3]));
      m1.select(cmb[1], cmb[0], ack);
      check(32'(ack), 32'(exp_acc));
      @(posedge i_clk);
      check(32'(resp[0].unsol_exc), 32'(exp_acc));
      m1.send(ev(SRST));
      m1.select(1'b0, 1'b0, ack);
      check(32'(ack), 32'h1);
      m1.desel();
      bus(1'b1, 32'h4, 32'hF);
    end
    // Alternate-port flags and their clearing
    m1.send(ev(RDONE));
    bus(1'b0, 32'h4, '0);
    check(rd & 32'hF, 32'h1);
    m1.send(ev(FMT));
    m1.send(ev(TMC));
    bus(1'b0, 32'h4, '0);
    check(rd & 32'hF, 32'hD);
    bus(1'b1, 32'h4, 32'hF);
    bus(1'b0, 32'h4, '0);
    check(rd & 32'hF, 32'h0);
    // Semaphore and notify codes at port 1 flag port 0
    for (int k = 0; k < 3; k++) begin
      m1.select(1'b0, 1'b0, ack);
      m1.code((k == 0) ? FC_SEM_A : (k == 1) ? FC_SEM_B : FC_NOTIFY_FMT);
      m1.desel();
      bus(1'b0, 32'h4, '0);
      check(rd & 32'hF, 32'h1);
      bus(1'b1, 32'h4, 32'hF);
    end
    // Port 1 flags: clear, then a format change at port 0
    bus(1'b1, 32'h8, 32'hF);
    @(posedge i_clk);
    check(32'(resp[1].unsol_exc), 32'h0);
    m0.send(ev(FMT));
    @(posedge i_clk);
    check(32'(resp[1].unsol_exc), 32'h1);
    bus(1'b0, 32'h8, '0);
    check(rd & 32'hF, 32'h5);
    // Disabled port refuses selections
    bus(1'b1, 32'h0, 32'hD);
    m1.select(1'b0, 1'b0, ack);
    check(32'(ack), 32'h0);
    bus(1'b0, 32'hC, '0);
    check(rd & 32'h33, 32'h1);
    tally_and_finish();
  end
endmodule // tb_dual_port_allegiance_control
